// ### src/fpx_timing_regs.sv
// indexed panel and extended horizontal timing register bank with its panel controls
module fpx_timing_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic pixel_tick,
  input wire logic line_start,
  input wire logic frame_start,
  input wire logic [7:0] pix_data,
  input wire logic [17:0] mem_addr_in,
  input wire logic ac_polarity_in,
  input wire logic line_pulse_in,
  input wire logic display_window,
  input wire logic fb_enable,
  input wire logic [1:0] misc_output_reg,
  input wire logic panel_600_sel,
  input wire logic [8:0] half_panel_size,
  input wire logic [9:0] vertical_active_span,
  input wire logic [7:0] std_h_total,
  input wire logic [7:0] std_h_de_end,
  input wire logic [7:0] std_h_blank_start,
  input wire logic [5:0] std_h_blank_end,
  input wire logic [7:0] std_h_sync_start,
  input wire logic [4:0] std_h_sync_end,
  output logic [4:0] gray_phase_x,
  output logic [4:0] gray_phase_y,
  output logic [2:0] amp_mod_bits,
  output logic amp_mod_ground,
  output logic [1:0] dither_bits,
  output logic dither_on,
  output logic color_mod_bit,
  output logic [17:0] fb_mem_addr,
  output logic ac_polarity_pin,
  output logic line_pulse_pin,
  output logic line_buf_active,
  output logic [10:0] line_buf_addr,
  output logic [10:0] line_buf_pixels,
  output logic [8:0] h_total,
  output logic [8:0] h_de_end,
  output logic [8:0] h_blank_start,
  output logic [5:0] h_blank_end,
  output logic [7:0] h_sync_start,
  output logic [4:0] h_sync_end,
  output logic [2:0] v_group,
  output logic std_timing_locked,
  output logic [9:0] half_panel_lines,
  output logic text_exp_per_row,
  output logic panel_if_24bit
);

  logic [7:0] index_q;
  logic [7:0] regs_q [fpx_pkg::NUM_REGS];
  logic [4:0] x_cnt_q;
  logic [4:0] y_cnt_q;
  logic [10:0] lb_cnt_q;

  // index of a bank register, valid only inside the extended window
  function automatic logic [3:0] slot(input logic [7:0] idx);
    logic [7:0] rel;
    rel = idx - fpx_pkg::IDX_X_OFF;
    slot = rel[3:0];
  endfunction : slot

  function automatic logic in_bank(input logic [7:0] idx);
    in_bank = (idx >= fpx_pkg::IDX_X_OFF) && (idx <= fpx_pkg::IDX_SPARE);
  endfunction : in_bank

  // one 2-bit slice starting at lsb
  function automatic logic [1:0] field2(input logic [7:0] r, input int lsb);
    field2 = r[lsb +: 2];
  endfunction : field2

  wire [7:0] r_x = regs_q[slot(fpx_pkg::IDX_X_OFF)];
  wire [7:0] r_y = regs_q[slot(fpx_pkg::IDX_Y_OFF)];
  wire [7:0] r_fb = regs_q[slot(fpx_pkg::IDX_FB_PIN)];
  wire [7:0] r_lb = regs_q[slot(fpx_pkg::IDX_LB_LEN)];
  wire [7:0] r_ctl = regs_q[slot(fpx_pkg::IDX_EXT_CTL)];
  wire [7:0] r_ht = regs_q[slot(fpx_pkg::IDX_H_TOTAL)];
  wire [7:0] r_hde = regs_q[slot(fpx_pkg::IDX_H_DE_END)];
  wire [7:0] r_hbs = regs_q[slot(fpx_pkg::IDX_H_BLK_ST)];
  wire [7:0] r_hbe = regs_q[slot(fpx_pkg::IDX_H_BLK_END)];
  wire [7:0] r_hss = regs_q[slot(fpx_pkg::IDX_H_SYNC_ST)];
  wire [7:0] r_hse = regs_q[slot(fpx_pkg::IDX_H_SYNC_END)];

  wire idx_sel = (io_addr == fpx_pkg::IO_INDEX);
  wire dat_sel = (io_addr == fpx_pkg::IO_DATA);
  wire ext_h = r_ctl[fpx_pkg::EXT_H_BIT];
  wire ext_v = r_ctl[fpx_pkg::EXT_V_BIT];
  wire [10:0] lb_len_px = {r_lb[5:0], 5'h00};

  // index port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      index_q <= fpx_pkg::INDEX_RESET;
    end else if (io_wr && idx_sel) begin
      index_q <= io_wdata;
    end
  end

  // data port; whole byte kept so reserved bits read back as written
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < fpx_pkg::NUM_REGS; i++) begin
        regs_q[i] <= fpx_pkg::REG_RESET;
      end
    end else if (io_wr && dat_sel && in_bank(index_q)) begin
      regs_q[slot(index_q)] <= io_wdata;
    end
  end

  // read answer one cycle after the strobe; unmapped indexes read zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      io_rdata <= 8'h00;
    end else if (io_rd && idx_sel) begin
      io_rdata <= index_q;
    end else if (io_rd && dat_sel) begin
      io_rdata <= in_bank(index_q) ? regs_q[slot(index_q)] : 8'h00;
    end
  end

  // gray-modulation pattern position counters
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      x_cnt_q <= 5'h00;
    end else if (line_start) begin
      x_cnt_q <= 5'h00;
    end else if (pixel_tick) begin
      x_cnt_q <= x_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      y_cnt_q <= 5'h00;
    end else if (frame_start) begin
      y_cnt_q <= 5'h00;
    end else if (line_start) begin
      y_cnt_q <= y_cnt_q + 5'h01;
    end
  end

  // offsets only shift the phase; pattern itself lives downstream
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gray_phase_x <= 5'h00;
      gray_phase_y <= 5'h00;
    end else begin
      gray_phase_x <= x_cnt_q + r_x[4:0];
      gray_phase_y <= y_cnt_q + r_y[4:0];
    end
  end

  // amplitude modulation selection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      amp_mod_bits <= 3'h0;
      amp_mod_ground <= 1'b0;
    end else begin
      unique case (field2(r_x, fpx_pkg::MODE_LSB))
        2'b00: begin
          amp_mod_bits <= 3'h0;
          amp_mod_ground <= 1'b0;
        end
        2'b01: begin
          amp_mod_bits <= {1'b0, pix_data[1:0]};
          amp_mod_ground <= 1'b1;
        end
        2'b10: begin
          amp_mod_bits <= pix_data[2:0];
          amp_mod_ground <= 1'b0;
        end
        2'b11: begin
          amp_mod_bits <= pix_data[3:1];
          amp_mod_ground <= 1'b0;
        end
      endcase
    end
  end

  // dithering pair and color modulation bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dither_bits <= 2'h0;
      dither_on <= 1'b0;
      color_mod_bit <= 1'b0;
    end else begin
      unique case (field2(r_y, fpx_pkg::MODE_LSB))
        2'b00: begin
          dither_bits <= 2'h0;
          dither_on <= 1'b0;
          color_mod_bit <= 1'b0;
        end
        2'b01: begin
          dither_bits <= pix_data[1:0];
          dither_on <= 1'b1;
          color_mod_bit <= r_y[fpx_pkg::DITHER_ALGO_BIT] ? pix_data[0] : pix_data[2];
        end
        2'b10: begin
          dither_bits <= pix_data[2:1];
          dither_on <= 1'b1;
          color_mod_bit <= r_y[fpx_pkg::DITHER_ALGO_BIT] ? pix_data[0] : pix_data[3];
        end
        2'b11: begin
          dither_bits <= pix_data[3:2];
          dither_on <= 1'b1;
          color_mod_bit <= r_y[fpx_pkg::DITHER_ALGO_BIT] ? pix_data[0] : pix_data[4];
        end
      endcase
    end
  end

  // frame buffer placement in video memory
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fb_mem_addr <= 18'h00000;
    end else begin
      fb_mem_addr <= {r_fb[fpx_pkg::FB_BASE_LSB +: 4], mem_addr_in[fpx_pkg::MEM_BASE_LSB-1:0]};
    end
  end

  // output pin functions; display window drives active low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ac_polarity_pin <= 1'b0;
      line_pulse_pin <= 1'b0;
    end else begin
      ac_polarity_pin <= r_fb[fpx_pkg::AC_PIN_SEL_BIT] ? ~display_window : ac_polarity_in;
      line_pulse_pin <= r_fb[fpx_pkg::LP_PIN_SEL_BIT] ? ~display_window : line_pulse_in;
    end
  end

  // line buffer write position; a zero length keeps it idle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lb_cnt_q <= 11'h000;
    end else if (!fb_enable || line_start) begin
      lb_cnt_q <= 11'h000;
    end else if (pixel_tick && (lb_len_px != 11'h000)) begin
      lb_cnt_q <= (lb_cnt_q == lb_len_px - 11'h001) ? 11'h000 : lb_cnt_q + 11'h001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_buf_active <= 1'b0;
      line_buf_addr <= 11'h000;
      line_buf_pixels <= 11'h000;
    end else begin
      line_buf_active <= fb_enable && (lb_len_px != 11'h000);
      line_buf_addr <= lb_cnt_q;
      line_buf_pixels <= lb_len_px;
    end
  end

  // effective horizontal timing; extended total, display end and blank start carry their bias back
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      h_total <= 9'h000;
      h_de_end <= 9'h000;
      h_blank_start <= 9'h000;
      h_blank_end <= 6'h00;
      h_sync_start <= 8'h00;
      h_sync_end <= 5'h00;
    end else if (ext_h) begin
      h_total <= {1'b0, r_ht} + fpx_pkg::H_TOTAL_ADJ;
      h_de_end <= {1'b0, r_hde} + fpx_pkg::H_ONE_ADJ;
      h_blank_start <= {1'b0, r_hbs} + fpx_pkg::H_ONE_ADJ;
      h_blank_end <= r_hbe[5:0];
      h_sync_start <= r_hss;
      h_sync_end <= r_hse[4:0];
    end else begin
      // standard set keeps its own bias rules elsewhere
      h_total <= {1'b0, std_h_total};
      h_de_end <= {1'b0, std_h_de_end};
      h_blank_start <= {1'b0, std_h_blank_start};
      h_blank_end <= std_h_blank_end;
      h_sync_start <= std_h_sync_start;
      h_sync_end <= std_h_sync_end;
    end
  end

  // vertical group choice
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      v_group <= fpx_pkg::FPX_V_STANDARD;
    end else if (!ext_v) begin
      v_group <= fpx_pkg::FPX_V_STANDARD;
    end else begin
      unique case (misc_output_reg)
        2'b00: v_group <= fpx_pkg::FPX_V_RESERVED;
        2'b01: v_group <= fpx_pkg::FPX_V_400;
        2'b10: v_group <= fpx_pkg::FPX_V_350;
        2'b11: v_group <= panel_600_sel ? fpx_pkg::FPX_V_600 : fpx_pkg::FPX_V_480;
      endcase
    end
  end

  // mode bits handed to the timing core and panel data path
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      std_timing_locked <= 1'b0;
      text_exp_per_row <= 1'b0;
      panel_if_24bit <= 1'b0;
    end else begin
      std_timing_locked <= r_ctl[fpx_pkg::LOCK_BIT];
      text_exp_per_row <= r_ctl[fpx_pkg::TEXT_EXP_BIT];
      panel_if_24bit <= r_ctl[fpx_pkg::PANEL24_BIT];
    end
  end

  // half-panel line count; odd spans round down
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      half_panel_lines <= 10'h000;
    end else if (r_ctl[fpx_pkg::HALF_SRC_BIT]) begin
      half_panel_lines <= {1'b0, vertical_active_span[9:1]};
    end else begin
      half_panel_lines <= {1'b0, half_panel_size};
    end
  end

endmodule : fpx_timing_regs

// ### src/fpx_pkg.sv
// constants for the flat panel extended timing register bank
package fpx_pkg;
  localparam logic [15:0] IO_INDEX = 16'h03D4;
  localparam logic [15:0] IO_DATA = 16'h03D5;
  localparam logic [7:0] IDX_X_OFF = 8'hA8;
  localparam logic [7:0] IDX_Y_OFF = 8'hA9;
  localparam logic [7:0] IDX_FB_PIN = 8'hAA;
  localparam logic [7:0] IDX_LB_LEN = 8'hAB;
  localparam logic [7:0] IDX_EXT_CTL = 8'hAC;
  localparam logic [7:0] IDX_H_TOTAL = 8'hAD;
  localparam logic [7:0] IDX_H_DE_END = 8'hAE;
  localparam logic [7:0] IDX_H_BLK_ST = 8'hAF;
  localparam logic [7:0] IDX_H_BLK_END = 8'hB0;
  localparam logic [7:0] IDX_H_SYNC_ST = 8'hB1;
  localparam logic [7:0] IDX_H_SYNC_END = 8'hB2;
  localparam logic [7:0] IDX_SPARE = 8'hB3;
  localparam int NUM_REGS = 12;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam int OFF_LSB = 0;
  localparam int MODE_LSB = 5;
  localparam int DITHER_ALGO_BIT = 7;
  localparam int FB_BASE_LSB = 0;
  localparam int AC_PIN_SEL_BIT = 5;
  localparam int LP_PIN_SEL_BIT = 6;
  localparam int LB_LEN_LSB = 0;
  localparam int EXT_H_BIT = 0;
  localparam int EXT_V_BIT = 1;
  localparam int LOCK_BIT = 2;
  localparam int HALF_SRC_BIT = 3;
  localparam int TEXT_EXP_BIT = 4;
  localparam int PANEL24_BIT = 5;
  localparam int MEM_BASE_LSB = 14;
  localparam int LB_UNIT_SHIFT = 5;
  localparam logic [8:0] H_TOTAL_ADJ = 9'h005;
  localparam logic [8:0] H_ONE_ADJ = 9'h001;
  typedef enum logic [2:0] {
    FPX_V_STANDARD = 3'b000,
    FPX_V_RESERVED = 3'b001,
    FPX_V_400 = 3'b010,
    FPX_V_350 = 3'b011,
    FPX_V_480 = 3'b100,
    FPX_V_600 = 3'b101
  } fpx_vgroup_e;
endpackage : fpx_pkg

// ### sim/fpx_timing_regs_monitor.sv
// concurrent checks on the panel timing register bank ports
module fpx_timing_regs_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic [17:0] mem_addr_in,
  input wire logic [17:0] fb_mem_addr,
  input wire logic display_window,
  input wire logic ac_polarity_in,
  input wire logic ac_polarity_pin,
  input wire logic fb_enable,
  input wire logic line_buf_active,
  input wire logic [10:0] line_buf_pixels,
  input wire logic [7:0] std_h_total,
  input wire logic [8:0] h_total,
  input wire logic std_timing_locked,
  input wire logic [2:0] v_group
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] idx_q;
  logic [7:0] m_q [12];
  logic [7:0] e_q [12];
  logic [1:0] live_q;
  wire hit = io_addr == fpx_pkg::IO_DATA && idx_q >= 8'hA8 && idx_q <= 8'hB3;
  wire [3:0] sl = 4'(idx_q - 8'hA8);
  // e_q lags the bank one clock, as the output stage does
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idx_q <= 8'h00;
      live_q <= 2'h0;
      m_q <= '{default: 8'h00};
      e_q <= '{default: 8'h00};
    end else begin
      idx_q <= (io_wr && io_addr == fpx_pkg::IO_INDEX) ? io_wdata : idx_q;
      live_q <= {live_q[0], 1'b1};
      e_q <= m_q;
      if (io_wr && hit) m_q[sl] <= io_wdata;
    end
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);
  rd_back_a: assert property (io_rd && hit |=> io_rdata == $past(m_q[sl]))
    else $error("read data wrong");
  rd_refuse_a: assert property (io_rd && io_addr == fpx_pkg::IO_DATA && !hit |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (live_q[1] && !io_rd |=> $stable(io_rdata))
    else $error("read data moved");
  fb_base_a: assert property (live_q[1] |-> fb_mem_addr == {e_q[2][3:0], $past(mem_addr_in[13:0])})
    else $error("frame address wrong");
  ac_pin_a: assert property (live_q[1] |->
    ac_polarity_pin == (e_q[2][5] ? !$past(display_window) : $past(ac_polarity_in))) else $error("ac pin wrong");
  lb_len_a: assert property (live_q[1] |-> line_buf_pixels == {e_q[3][5:0], 5'h00})
    else $error("line length wrong");
  lb_idle_a: assert property ((!fb_enable) [*2] |-> !line_buf_active)
    else $error("line buffer runs idle");
  h_total_a: assert property (live_q[1] |->
    h_total == (e_q[4][0] ? 9'(e_q[5]) + 9'h005 : 9'($past(std_h_total)))) else $error("total wrong");
  lock_a: assert property (live_q[1] |-> std_timing_locked == e_q[4][2]) else $error("lock wrong");
  v_std_a: assert property (live_q[1] && !e_q[4][1] |-> v_group == 3'h0) else $error("group wrong");
  ext_c: cover property (io_wr && hit && sl == 4'h4);
  rd_c: cover property (io_rd && hit);
  lb_c: cover property (fb_enable && line_buf_active);
endmodule : fpx_timing_regs_monitor

bind fpx_timing_regs fpx_timing_regs_monitor u_fpx_timing_regs_monitor (.clk, .rstn, .io_addr, .io_wr, .io_rd,
  .io_wdata, .io_rdata, .mem_addr_in, .fb_mem_addr, .display_window, .ac_polarity_in, .ac_polarity_pin,
  .fb_enable, .line_buf_active, .line_buf_pixels, .std_h_total, .h_total, .std_timing_locked, .v_group);

// ### sim/fpx_panel_model.sv
// panel side timing source that keeps its own pixel and line tally
module fpx_panel_model (
  input wire logic clk,
  input wire logic go,
  output logic pixel_tick,
  output logic line_start,
  output logic frame_start,
  output logic display_window,
  output logic ac_polarity_in,
  output logic line_pulse_in,
  output logic [4:0] px_cnt,
  output logic [4:0] ln_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos = 0;
  int ln = 0;
  // 40-clock lines, 3-line frames; quiet while go is low so the tally stays put
  // one process owns every output, so the start values have no second driver
  initial begin
    {pixel_tick, line_start, frame_start, display_window, ac_polarity_in, line_pulse_in, px_cnt, ln_cnt} = '0;
    forever @(negedge clk) begin
      line_start = go && pos == 0;
      frame_start = line_start && ln == 0;
      pixel_tick = go && pos != 0;
      display_window = go && pos > 2 && pos < 36;
      line_pulse_in = go && pos == 39;
      if (frame_start) ac_polarity_in = !ac_polarity_in;
      if (line_start) px_cnt = 5'h00;
      else if (pixel_tick) px_cnt = px_cnt + 5'h01;
      if (frame_start) ln_cnt = 5'h00;
      else if (line_start) ln_cnt = ln_cnt + 5'h01;
      if (go) pos = (pos + 1) % 40;
      if (go && pos == 0) ln = (ln + 1) % 3;
    end
  end
endmodule : fpx_panel_model

// ### sim/fpx_timing_regs_tb_top.sv
// self-checking bench for the panel timing register bank
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin n_fail++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module fpx_timing_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, io_wr, io_rd, go, fb_enable, panel_600_sel, pixel_tick, line_start, frame_start, display_window;
  logic ac_polarity_in, line_pulse_in, amp_mod_ground, dither_on, color_mod_bit, ac_polarity_pin, line_pulse_pin;
  logic line_buf_active, std_timing_locked, text_exp_per_row, panel_if_24bit, rd_q;
  logic [1:0] misc_output_reg, dither_bits, dm;
  logic [2:0] amp_mod_bits, v_group, ve;
  logic [4:0] gray_phase_x, gray_phase_y, h_sync_end, std_h_sync_end, px_cnt, ln_cnt;
  logic [5:0] std_h_blank_end, h_blank_end;
  logic [7:0] io_wdata, io_rdata, pix_data, std_h_total, std_h_de_end, std_h_blank_start, ev, ac;
  logic [7:0] std_h_sync_start, h_sync_start;
  logic [8:0] half_panel_size, h_total, h_de_end, h_blank_start;
  logic [9:0] vertical_active_span, half_panel_lines;
  logic [10:0] line_buf_addr, line_buf_pixels;
  logic [15:0] io_addr;
  logic [17:0] mem_addr_in, fb_mem_addr;
  logic [31:0] rnd = 32'h8287B19E;
  logic [7:0] exp_q [$];
  int n_fail = 0;
  int n_compared = 0;
  fpx_timing_regs u_fpx_timing_regs (.*);
  fpx_panel_model u_fpx_panel_model (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wr = w;
    io_rd = !w;
    io_wdata = d;
    @(negedge clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
  endtask : io
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    io(fpx_pkg::IO_INDEX, 1'b1, i);
    io(fpx_pkg::IO_DATA, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    io(fpx_pkg::IO_INDEX, 1'b1, i);
    exp_q.push_back(e);
    io(fpx_pkg::IO_DATA, 1'b0, 8'h00);
  endtask : rd
  // the write is already stored; one clock to reach the outputs, two spare
  task automatic st();
    repeat (3) @(negedge clk);
  endtask : st
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  always @(posedge clk) rd_q <= io_rd && io_addr == fpx_pkg::IO_DATA;
  always @(negedge clk) begin
    if (rd_q) begin
      ev = exp_q.pop_front();
      `CHK("io_rdata", ev, io_rdata)
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  initial begin
    {io_wr, io_rd, go, fb_enable, panel_600_sel, io_addr, io_wdata, pix_data, mem_addr_in, misc_output_reg} = '0;
    {half_panel_size, vertical_active_span, std_h_total, std_h_de_end, std_h_blank_start} = '0;
    {std_h_blank_end, std_h_sync_start, std_h_sync_end} = '0;
    rstn = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 12; i++) rd(8'hA8 + 8'(i), 8'h00);
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      wr(8'hA8 + 8'(i), rnd[7:0]);
      rd(8'hA8 + 8'(i), rnd[7:0]);
    end
    wr(8'hA7, 8'h5A);
    rd(8'hA7, 8'h00);
    rd(8'hB4, 8'h00);
    rnd = lfsr(rnd);
    {std_h_total, std_h_de_end, std_h_blank_start, std_h_sync_start} = rnd;
    {std_h_blank_end, std_h_sync_end} = rnd[10:0];
    // all-ones shows the added bias carrying into bit 8
    for (int i = 5; i < 11; i++) wr(8'hA8 + 8'(i), 8'hFF);
    for (int e = 0; e < 2; e++) begin
      wr(fpx_pkg::IDX_EXT_CTL, 8'(e));
      st();
      `CHK("h_total", e ? 9'h104 : {1'b0, std_h_total}, h_total)
      `CHK("h_de_end", e ? 9'h100 : {1'b0, std_h_de_end}, h_de_end)
      `CHK("h_blank_start", e ? 9'h100 : {1'b0, std_h_blank_start}, h_blank_start)
      `CHK("h_blank_end", e ? 6'h3F : std_h_blank_end, h_blank_end)
      `CHK("h_sync_start", e ? 8'hFF : std_h_sync_start, h_sync_start)
      `CHK("h_sync_end", e ? 5'h1F : std_h_sync_end, h_sync_end)
    end
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      ac = {rnd[7:2], i != 0, rnd[0]};
      {panel_600_sel, misc_output_reg} = 3'(i);
      {half_panel_size, vertical_active_span} = rnd[26:8];
      wr(fpx_pkg::IDX_EXT_CTL, ac);
      st();
      ve = misc_output_reg == 2'h3 ? 3'h4 + 3'(panel_600_sel) : 3'h1 + 3'(misc_output_reg);
      `CHK("v_group", ac[1] ? ve : 3'h0, v_group)
      `CHK("half_lines", ac[3] ? vertical_active_span >> 1 : {1'b0, half_panel_size}, half_panel_lines)
      `CHK("text_exp", ac[4], text_exp_per_row)
      `CHK("if_24bit", ac[5], panel_if_24bit)
      `CHK("locked", ac[2], std_timing_locked)
    end
    go = 1'b1;
    // ends on the 32-pixel length, so the buffer position matches the 5-bit pixel tally
    for (int n = 63; n > 0; n -= 62) begin
      wr(fpx_pkg::IDX_LB_LEN, {2'h3, 6'(n)});
      st();
      `CHK("lb_pixels", {6'(n), 5'h00}, line_buf_pixels)
    end
    repeat (20) @(negedge clk) `CHK("lb_active", 1'b0, line_buf_active)
    fb_enable = 1'b1;
    for (int k = 0; k < 80 && line_buf_active !== 1'b1; k++) @(negedge clk);
    `CHK("lb_active", 1'b1, line_buf_active)
    // let a line start pass with the buffer enabled so both counts restart together
    repeat (45) @(negedge clk);
    go = 1'b0;
    st();
    `CHK("lb_addr", {6'h00, px_cnt}, line_buf_addr)
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      mem_addr_in = rnd[17:0];
      wr(fpx_pkg::IDX_FB_PIN, {rnd[22], 2'(i), rnd[23], rnd[21:18]});
      st();
      `CHK("lp_pin", i[1] ? !display_window : line_pulse_in, line_pulse_pin)
      `CHK("ac_pin", i[0] ? !display_window : ac_polarity_in, ac_polarity_pin)
      `CHK("fb_addr", {rnd[21:18], mem_addr_in[13:0]}, fb_mem_addr)
    end
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      pix_data = rnd[7:0];
      dm = 2'(i);
      wr(fpx_pkg::IDX_X_OFF, {rnd[8], dm, rnd[13:9]});
      wr(fpx_pkg::IDX_Y_OFF, {i[2], dm, rnd[18:14]});
      st();
      `CHK("phase_x", px_cnt + rnd[13:9], gray_phase_x)
      `CHK("phase_y", ln_cnt + rnd[18:14], gray_phase_y)
      `CHK("dither_on", dm != 2'h0, dither_on)
      if (dm != 2'h0) `CHK("dither_bits", pix_data[dm - 2'h1 +: 2], dither_bits)
      `CHK("mod_bit", dm == 2'h0 ? 1'b0 : i[2] ? pix_data[0] : pix_data[3'(dm) + 3'h1], color_mod_bit)
      `CHK("amp_bits", dm == 2'h0 ? 3'h0 : dm == 2'h1 ? {1'b0, pix_data[1:0]} : pix_data[dm - 2'h2 +: 3], amp_mod_bits)
      `CHK("amp_ground", dm == 2'h1, amp_mod_ground)
    end
    wrap_up();
  end
endmodule : fpx_timing_regs_tb_top
